// ===== include/vcap_pkg.sv
// Constants shared by the capture channel A control bank
package vcap_pkg;
  // ********************************************************************
  // Register byte offsets
  // ********************************************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] ISTAT_OFS = 4'h8;
  localparam logic [3:0] IMASK_OFS = 4'hC;
  // ********************************************************************
  // Control field positions
  // ********************************************************************
  localparam int CHANNEL_RESET_BIT_BIT = 31;
  localparam int BLK_BIT = 30;
  localparam int RAW_FIELD_IDENT_ENABLE_BIT = 21;
  localparam int DETECTED_FIELD_INVERT_BIT = 20;
  localparam int EXC_BIT = 19;
  localparam int CAPTURE_ENABLE_BIT_BIT = 15;
  // ********************************************************************
  // Status field positions
  // ********************************************************************
  localparam int FRAME_DONE_FLAG_BIT = 30;
  localparam int F2C_BIT = 29;
  localparam int F1C_BIT = 28;
  localparam int FLD_BIT = 12;
  // ********************************************************************
  // Interrupt status bits
  // ********************************************************************
  localparam int IRQ_F1 = 0;
  localparam int IRQ_F2 = 1;
  localparam int IRQ_FRM = 2;
  localparam int IRQ_RST = 3;
  localparam int IRQ_W = 4;
  // ********************************************************************
  // Reset values and masks
  // ********************************************************************
  localparam logic [31:0] CTRL_RST = 32'h4002_0030;
  localparam logic [31:0] CTRL_WMASK = 32'h403F_FDF7;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [IRQ_W-1:0] ISTAT_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IMASK_RST = 4'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage : vcap_pkg

// ===== include/vcap_evt_if.sv
// Signals between the control bank, event gate and reset sequencer
interface vcap_evt_if;
  logic block;
  logic frame_start;
  logic field_end;
  logic frame_end;
  logic field_two;
  logic data_req;
  logic dma_evt;
  logic f1_set;
  logic f2_set;
  logic frm_set;
  logic armed;
  logic rst_start;
  logic dma_pending;
  logic rst_busy;
  logic rst_flush;
  logic rst_done;
  modport ctl (
    output block, frame_start, field_end, frame_end, field_two, data_req,
    output rst_start, dma_pending,
    input dma_evt, f1_set, f2_set, frm_set, armed,
    input rst_busy, rst_flush, rst_done
  );
  modport gate (
    input block, frame_start, field_end, frame_end, field_two, data_req,
    output dma_evt, f1_set, f2_set, frm_set, armed
  );
  modport seq (
    input rst_start, dma_pending,
    output rst_busy, rst_flush, rst_done
  );
endinterface : vcap_evt_if

// ===== core/vcap_rst_seq.sv
// Channel reset sequencer: drain pending transfers, then flush
module vcap_rst_seq (
  input logic sys_clk,
  input logic sys_rst,
  vcap_evt_if.seq ev
);
  typedef enum logic [2:0] {
    VCAP_R_IDLE = 3'b001,
    VCAP_R_DRAIN = 3'b010,
    VCAP_R_FLUSH = 3'b100
  } vcap_rst_t;
  vcap_rst_t state_r;
  vcap_rst_t state_nxt;
  always_comb begin
    case (state_r)
      VCAP_R_IDLE: state_nxt = ev.rst_start ? VCAP_R_DRAIN : VCAP_R_IDLE;
      VCAP_R_DRAIN: state_nxt = ev.dma_pending ? VCAP_R_DRAIN : VCAP_R_FLUSH;
      VCAP_R_FLUSH: state_nxt = VCAP_R_IDLE;
      default: state_nxt = VCAP_R_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= VCAP_R_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign ev.rst_busy = (state_r != VCAP_R_IDLE);
  assign ev.rst_flush = (state_r == VCAP_R_FLUSH);
  assign ev.rst_done = (state_r == VCAP_R_FLUSH);
  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_flush_drained: assert property (
    $rose(ev.rst_flush) |-> !$past(ev.dma_pending) && $past(ev.rst_busy))
    else $error("flush began with transfers pending");
  a_drain_hold: assert property (
    (state_r == VCAP_R_DRAIN && ev.dma_pending) |=> !ev.rst_flush)
    else $error("drain left early");
  a_rst_ends: assert property (
    ev.rst_done |=> !ev.rst_busy)
    else $error("reset did not end after flush");
endmodule : vcap_rst_seq

// ===== core/vcap_evt_gate.sv
// Capture event gate: blocking and resync to next frame start
module vcap_evt_gate (
  input logic sys_clk,
  input logic sys_rst,
  vcap_evt_if.gate ev
);
  typedef enum logic [2:0] {
    VCAP_G_HOLD = 3'b001,
    VCAP_G_SYNC = 3'b010,
    VCAP_G_RUN = 3'b100
  } vcap_gate_t;
  vcap_gate_t state_r;
  vcap_gate_t state_nxt;
  logic run;
  always_comb begin
    case (state_r)
      VCAP_G_HOLD: state_nxt = ev.block ? VCAP_G_HOLD : VCAP_G_SYNC;
      VCAP_G_SYNC: begin
        if (ev.block) begin
          state_nxt = VCAP_G_HOLD;
        end else if (ev.frame_start) begin
          state_nxt = VCAP_G_RUN;
        end else begin
          state_nxt = VCAP_G_SYNC;
        end
      end
      VCAP_G_RUN: state_nxt = ev.block ? VCAP_G_HOLD : VCAP_G_RUN;
      default: state_nxt = VCAP_G_HOLD;
    endcase
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= VCAP_G_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign run = (state_r == VCAP_G_RUN) && !ev.block;
  assign ev.armed = (state_r == VCAP_G_RUN);
  assign ev.dma_evt = run && ev.data_req;
  assign ev.f1_set = run && ev.field_end && !ev.field_two;
  assign ev.f2_set = run && ev.field_end && ev.field_two;
  assign ev.frm_set = run && ev.frame_end;
  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_blk_silent: assert property (
    ev.block |-> !(ev.dma_evt || ev.f1_set || ev.f2_set || ev.frm_set))
    else $error("event issued while blocked");
  a_resync_wait: assert property (
    (!ev.armed && !ev.frame_start) |=> !ev.armed)
    else $error("events resumed before frame start");
  a_resync_go: assert property (
    (state_r == VCAP_G_SYNC && !ev.block && ev.frame_start) |=> ev.armed)
    else $error("no resume at frame start");
endmodule : vcap_evt_gate

// ===== core/vcap_ctrl.sv
// Capture channel A control bank with Avalon-MM slave and interrupt
// Summary of operation
// - Writing one to bit 31 starts reset
// - Reset blocks capture, flushes after pending DMA
// - Reset forces capture enable to zero
// - Block bit stops DMA events, flushes FIFOs
// - Blocked: no flag updates, no field events
// - Blocking keeps other configuration untouched
// - Events resume only at next frame start
// - Bits 29 to 22 read zero
// - Raw mode: bit 21 enables field identification
// - Bit 20 inverts detected field in BT mode
// - Bit 19 selects external timing pins in BT mode
// - Bit 15 enables video capture
// - Done flags clear by writing one
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
module vcap_ctrl (
  input logic sys_clk,
  input logic sys_rst,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input logic dma_pending,
  input logic frame_start,
  input logic field_end,
  input logic frame_end,
  input logic detected_field,
  input logic data_req,
  input logic mode_bt_yc,
  input logic mode_raw,
  output logic capture_enable,
  output logic fifo_flush,
  output logic dma_event,
  output logic field_is_two,
  output logic field_ident_en,
  output logic ext_timing_sel,
  output logic [31:0] ctrl_cfg
);
  vcap_evt_if ev ();
  // ********************************************************************
  // Bus slave
  // ********************************************************************
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic acc;
  logic wr_ack;
  logic rd_ack;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_istat;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [2:0] stat_r;
  logic [2:0] stat_nxt;
  logic [vcap_pkg::IRQ_W-1:0] istat_r;
  logic [vcap_pkg::IRQ_W-1:0] istat_nxt;
  logic [vcap_pkg::IRQ_W-1:0] imask_r;
  logic [vcap_pkg::IRQ_W-1:0] imask_nxt;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic fld_val;
  assign acc = avs_read || avs_write;
  assign avs_waitrequest = acc && !ack_r;
  assign wr_ack = avs_write && ack_r;
  assign rd_ack = avs_read && ack_r;
  assign wr_ctrl = wr_ack && (avs_address == vcap_pkg::CTRL_OFS);
  assign wr_stat = wr_ack && (avs_address == vcap_pkg::STAT_OFS);
  assign rd_istat = rd_ack && (avs_address == vcap_pkg::ISTAT_OFS);
  always_comb begin
    ctrl_rd = ctrl_r;
    ctrl_rd[vcap_pkg::CHANNEL_RESET_BIT_BIT] = ev.rst_busy;
  end
  always_comb begin
    stat_rd = 32'h0000_0000;
    stat_rd[vcap_pkg::F1C_BIT] = stat_r[0];
    stat_rd[vcap_pkg::F2C_BIT] = stat_r[1];
    stat_rd[vcap_pkg::FRAME_DONE_FLAG_BIT] = stat_r[2];
    stat_rd[vcap_pkg::FLD_BIT] = field_is_two;
  end
  always_comb begin
    ack_nxt = acc && !ack_r;
    rdata_nxt = rdata_r;
    if (acc && !ack_r) begin
      case (avs_address)
        vcap_pkg::CTRL_OFS: rdata_nxt = ctrl_rd;
        vcap_pkg::STAT_OFS: rdata_nxt = stat_rd;
        vcap_pkg::ISTAT_OFS: rdata_nxt = {28'h0, istat_r};
        vcap_pkg::IMASK_OFS: rdata_nxt = {28'h0, imask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= vcap_pkg::RDATA_RST;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign avs_readdata = rdata_r;
  // ********************************************************************
  // Control register
  // ********************************************************************
  // Start channel reset
  assign ev.rst_start = wr_ctrl && avs_writedata[vcap_pkg::CHANNEL_RESET_BIT_BIT]
                        && !ev.rst_busy;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl && !ev.rst_busy && !avs_writedata[vcap_pkg::CHANNEL_RESET_BIT_BIT]) begin
      ctrl_nxt = avs_writedata & vcap_pkg::CTRL_WMASK;
    end
    if (ev.rst_start || ev.rst_busy) begin
      ctrl_nxt[vcap_pkg::CAPTURE_ENABLE_BIT_BIT] = 1'b0;
    end
    if (ev.rst_done) begin
      ctrl_nxt = vcap_pkg::CTRL_RST;
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= vcap_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  // ********************************************************************
  // Status flags and interrupt
  // ********************************************************************
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt[0] = stat_r[0] && !avs_writedata[vcap_pkg::F1C_BIT];
      stat_nxt[1] = stat_r[1] && !avs_writedata[vcap_pkg::F2C_BIT];
      stat_nxt[2] = stat_r[2] && !avs_writedata[vcap_pkg::FRAME_DONE_FLAG_BIT];
    end
    if (ev.rst_done) begin
      stat_nxt = vcap_pkg::STAT_RST;
    end
    stat_nxt = stat_nxt | {ev.frm_set, ev.f2_set, ev.f1_set};
    istat_nxt = istat_r;
    if (rd_istat) begin
      istat_nxt = istat_r & ~rdata_r[vcap_pkg::IRQ_W-1:0];
    end
    istat_nxt[vcap_pkg::IRQ_F1] = istat_nxt[vcap_pkg::IRQ_F1] || ev.f1_set;
    istat_nxt[vcap_pkg::IRQ_F2] = istat_nxt[vcap_pkg::IRQ_F2] || ev.f2_set;
    istat_nxt[vcap_pkg::IRQ_FRM] = istat_nxt[vcap_pkg::IRQ_FRM] || ev.frm_set;
    istat_nxt[vcap_pkg::IRQ_RST] = istat_nxt[vcap_pkg::IRQ_RST] || ev.rst_done;
    imask_nxt = imask_r;
    if (wr_ack && (avs_address == vcap_pkg::IMASK_OFS)) begin
      imask_nxt = avs_writedata[vcap_pkg::IRQ_W-1:0];
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_r <= vcap_pkg::STAT_RST;
      istat_r <= vcap_pkg::ISTAT_RST;
      imask_r <= vcap_pkg::IMASK_RST;
    end else begin
      stat_r <= stat_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
    end
  end
  // ********************************************************************
  // Event gate and reset sequencer
  // ********************************************************************
  // Block leaves config
  assign ev.block = ctrl_r[vcap_pkg::BLK_BIT] || ev.rst_busy;
  assign ev.frame_start = frame_start;
  assign ev.field_end = field_end;
  assign ev.frame_end = frame_end;
  assign ev.field_two = fld_val;
  assign ev.data_req = data_req;
  assign ev.dma_pending = dma_pending;
  always_comb begin
    fld_val = 1'b0;
    if (mode_bt_yc) begin
      fld_val = detected_field ^ ctrl_r[vcap_pkg::DETECTED_FIELD_INVERT_BIT];
    end else if (mode_raw && ctrl_r[vcap_pkg::RAW_FIELD_IDENT_ENABLE_BIT]) begin
      fld_val = detected_field;
    end
  end
  vcap_evt_gate u_gate (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ev(ev)
  );
  vcap_rst_seq u_seq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ev(ev)
  );
  // ********************************************************************
  // Registered outputs
  // ********************************************************************
  logic cap_en_nxt;
  logic flush_nxt;
  logic dma_nxt;
  logic ident_nxt;
  logic ext_nxt;
  logic irq_nxt;
  always_comb begin
    cap_en_nxt = ctrl_r[vcap_pkg::CAPTURE_ENABLE_BIT_BIT] && !ev.rst_busy;
    flush_nxt = (ctrl_r[vcap_pkg::BLK_BIT] && !ev.rst_busy) || ev.rst_flush;
    dma_nxt = ev.dma_evt && ctrl_r[vcap_pkg::CAPTURE_ENABLE_BIT_BIT];
    ident_nxt = mode_raw && ctrl_r[vcap_pkg::RAW_FIELD_IDENT_ENABLE_BIT];
    ext_nxt = mode_bt_yc && ctrl_r[vcap_pkg::EXC_BIT];
    irq_nxt = |(istat_r & imask_r);
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_enable <= 1'b0;
      fifo_flush <= 1'b0;
      dma_event <= 1'b0;
      field_is_two <= 1'b0;
      field_ident_en <= 1'b0;
      ext_timing_sel <= 1'b0;
      irq <= 1'b0;
      ctrl_cfg <= vcap_pkg::CTRL_RST;
    end else begin
      capture_enable <= cap_en_nxt;
      fifo_flush <= flush_nxt;
      dma_event <= dma_nxt;
      field_is_two <= fld_val;
      field_ident_en <= ident_nxt;
      ext_timing_sel <= ext_nxt;
      irq <= irq_nxt;
      ctrl_cfg <= ctrl_r;
    end
  end
  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rst_req;
    wr_ctrl && avs_writedata[vcap_pkg::CHANNEL_RESET_BIT_BIT] && !ev.rst_busy;
  endsequence
  sequence s_rst_run;
    ev.rst_busy ##1 !capture_enable;
  endsequence
  a_rst_start: assert property (
    s_rst_req |=> s_rst_run)
    else $error("reset write did not start reset");
  a_zero_noop: assert property (
    (wr_ctrl && !avs_writedata[vcap_pkg::CHANNEL_RESET_BIT_BIT] && !ev.rst_busy)
    |=> !ev.rst_busy)
    else $error("zero write started reset");
  a_rst_capture_enable_bit: assert property (
    ev.rst_busy |=> !ctrl_r[vcap_pkg::CAPTURE_ENABLE_BIT_BIT])
    else $error("capture enabled during reset");
  a_rst_restore: assert property (
    ev.rst_done |=> ctrl_r == vcap_pkg::CTRL_RST && stat_r == 3'h0)
    else $error("registers not restored by reset");
  a_blk_flush: assert property (
    (ctrl_r[vcap_pkg::BLK_BIT] && !ev.rst_busy) |=> fifo_flush && !dma_event)
    else $error("blocked channel not flushing");
  a_rsvd_zero: assert property (
    (rd_ack && avs_address == vcap_pkg::CTRL_OFS)
    |-> avs_readdata[29:22] == 8'h00)
    else $error("reserved bits not zero");
  a_raw_ident: assert property (
    mode_raw |=> field_ident_en == $past(ctrl_r[vcap_pkg::RAW_FIELD_IDENT_ENABLE_BIT]))
    else $error("raw field ident wrong");
  a_field_map: assert property (
    mode_bt_yc
    |=> field_is_two == ($past(detected_field)
                         ^ $past(ctrl_r[vcap_pkg::DETECTED_FIELD_INVERT_BIT])))
    else $error("field inversion wrong");
  a_ext_sel: assert property (
    mode_bt_yc |=> ext_timing_sel == $past(ctrl_r[vcap_pkg::EXC_BIT]))
    else $error("timing select wrong");
  a_w1c_flag: assert property (
    (wr_stat && avs_writedata[vcap_pkg::F1C_BIT] && !ev.f1_set) |=> !stat_r[0])
    else $error("flag not cleared by write one");
  a_channel_reset_bit_self: assert property (
    ev.rst_done |=> ##1 (ctrl_rd[vcap_pkg::CHANNEL_RESET_BIT_BIT] == 1'b0))
    else $error("reset bit did not clear");
endmodule : vcap_ctrl

// ===== sim/tb_vcap_ctrl.sv
// Self-checking testbench for the capture channel A control bank
module tb_vcap_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************************
  // Signals
  // ********************************************************************
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic dma_pending = 1'b0;
  logic [3:0] pls = 4'h0;
  logic detected_field = 1'b0;
  logic mode_bt_yc = 1'b1;
  logic mode_raw = 1'b0;
  logic capture_enable;
  logic fifo_flush;
  logic dma_event;
  logic field_is_two;
  logic field_ident_en;
  logic ext_timing_sel;
  logic [31:0] ctrl_cfg;
  logic [31:0] rd;
  int n_errors = 0;
  int tests_run = 0;
  int n_dma = 0;
  int n_flush = 0;
  logic flush_q = 1'b0;
  // ********************************************************************
  // Design under test
  // ********************************************************************
  vcap_ctrl i_vcap_ctrl (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq),
    .dma_pending(dma_pending),
    .frame_start(pls[0]),
    .field_end(pls[1]),
    .frame_end(pls[2]),
    .detected_field(detected_field),
    .data_req(pls[3]),
    .mode_bt_yc(mode_bt_yc),
    .mode_raw(mode_raw),
    .capture_enable(capture_enable),
    .fifo_flush(fifo_flush),
    .dma_event(dma_event),
    .field_is_two(field_is_two),
    .field_ident_en(field_ident_en),
    .ext_timing_sel(ext_timing_sel),
    .ctrl_cfg(ctrl_cfg)
  );
  // ********************************************************************
  // Clock, monitors and watchdog
  // ********************************************************************
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (dma_event === 1'b1) n_dma++;
    // Count flush episodes, not flush cycles
    if (fifo_flush === 1'b1 && flush_q !== 1'b1) n_flush++;
    flush_q <= fifo_flush;
  end
  initial begin
    #(50 * 5000);
    n_errors++;
    give_verdict();
  end
  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic av_access(input logic wr, input logic [3:0] a,
                           input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic av_write(input logic [3:0] a, input logic [31:0] d);
    av_access(1'b1, a, d);
  endtask
  task automatic av_read(input logic [3:0] a, input logic [31:0] exp);
    av_access(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk);
    pls[k] <= 1'b1;
    @(posedge sys_clk);
    pls[k] <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ********************************************************************
  // Test sequence
  // ********************************************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check(ctrl_cfg, vcap_pkg::CTRL_RST); // Reset image
    av_read(vcap_pkg::CTRL_OFS, vcap_pkg::CTRL_RST); // Reset value
    av_read(vcap_pkg::STAT_OFS, 32'h0000_0000); // Flags clear
    av_read(4'h2, 32'h0000_0000); // Unmapped address
    // Every writable bit, channel reset bit left at zero
    av_write(vcap_pkg::CTRL_OFS, 32'h7FFF_FFFF);
    av_read(vcap_pkg::CTRL_OFS, 32'h403F_FDF7); // Reserved bits
    settle();
    check(ctrl_cfg, 32'h403F_FDF7); // Config kept while blocked
    check(capture_enable, 1'b1); // Enable bit
    check(ext_timing_sel, 1'b1); // External timing
    check(field_ident_en, 1'b0); // Ident off outside raw
    check(fifo_flush, 1'b1); // Flush while blocked
    check(field_is_two, 1'b1); // Inverted field
    @(posedge sys_clk);
    mode_bt_yc <= 1'b0;
    mode_raw <= 1'b1;
    settle();
    check(field_ident_en, 1'b1); // Ident in raw mode
    check(ext_timing_sel, 1'b0); // No pins outside BT mode
    @(posedge sys_clk);
    mode_bt_yc <= 1'b1;
    mode_raw <= 1'b0;
    // Events while blocked
    pulse(3);
    pulse(1);
    pulse(2);
    settle();
    check(n_dma, 0); // No DMA event blocked
    av_read(vcap_pkg::STAT_OFS, 32'h0000_1000); // No flag update
    av_read(vcap_pkg::ISTAT_OFS, 32'h0000_0000); // No field events
    // Unblock, enable, field not inverted
    av_write(vcap_pkg::CTRL_OFS, 32'h0000_8000);
    av_write(vcap_pkg::STAT_OFS, 32'h7000_0000); // Clear flags
    settle();
    check(fifo_flush, 1'b0); // Flush ends with block
    check(field_is_two, 1'b0); // Plain field mapping
    pulse(3);
    settle();
    check(n_dma, 0); // Still off before frame start
    pulse(0);
    settle();
    pulse(3);
    settle();
    check(n_dma, 1); // Resumed after frame start
    pulse(1);
    pulse(2);
    settle();
    av_read(vcap_pkg::STAT_OFS, 32'h5000_0000); // Field one and frame
    av_write(vcap_pkg::STAT_OFS, 32'h0000_0000);
    av_read(vcap_pkg::STAT_OFS, 32'h5000_0000); // Zero write ignored
    av_write(vcap_pkg::STAT_OFS, 32'h1000_0000);
    av_read(vcap_pkg::STAT_OFS, 32'h4000_0000); // One write clears
    // Interrupt raise, mask and clear by read
    settle();
    check(irq, 1'b0); // Masked events
    av_write(vcap_pkg::IMASK_OFS, 32'h0000_0005);
    settle();
    check(irq, 1'b1); // Unmasked events
    av_read(vcap_pkg::ISTAT_OFS, 32'h0000_0005); // Field and frame
    settle();
    check(irq, 1'b0); // Cleared by read
    av_read(vcap_pkg::ISTAT_OFS, 32'h0000_0000); // Cleared by read
    // Zero in the reset bit starts nothing
    av_write(vcap_pkg::CTRL_OFS, 32'h0000_8000);
    av_read(vcap_pkg::CTRL_OFS, 32'h0000_8000); // No reset
    av_read(vcap_pkg::ISTAT_OFS, 32'h0000_0000); // No reset done
    // Channel reset with transfers still pending
    dma_pending <= 1'b1;
    av_write(vcap_pkg::CTRL_OFS, 32'h8000_0000);
    n_flush = 0;
    settle();
    check(capture_enable, 1'b0); // Enable forced off
    av_access(1'b0, vcap_pkg::CTRL_OFS, 32'h0000_0000);
    check(rd[31], 1'b1); // Reset busy shown
    repeat (10) @(posedge sys_clk);
    check(n_flush, 0); // Flush waits for pending DMA
    dma_pending <= 1'b0;
    settle();
    settle();
    check(n_flush, 1); // Single flush after drain
    av_read(vcap_pkg::CTRL_OFS, vcap_pkg::CTRL_RST); // Self clear
    av_read(vcap_pkg::STAT_OFS, 32'h0000_0000); // Status restored
    av_read(vcap_pkg::ISTAT_OFS, 32'h0000_0008); // Reset done
    check(capture_enable, 1'b0); // Stays disabled
    give_verdict();
  end
endmodule // tb_vcap_ctrl
